// File: core/loop_cfg_pkg.sv
// Constants, field layouts and carrier types for the loop filter configuration bank
package loop_cfg_pkg;

    localparam int REG_W = 16;
    localparam int ADDR_W = 2;

    // Register indices on the internal register port
    localparam logic [1:0] IDX_TRIM = 2'h0;
    localparam logic [1:0] IDX_HOLD = 2'h1;
    localparam logic [1:0] IDX_BAND = 2'h2;
    localparam logic [1:0] IDX_DAMP = 2'h3;

    localparam logic [15:0] RST_TRIM = 16'h0000;
    localparam logic [15:0] RST_HOLD = 16'h3800;
    localparam logic [15:0] RST_BAND = 16'h7058;
    localparam logic [15:0] RST_DAMP = 16'h2901;

    // Writable bits of each register; the rest read as zero
    localparam logic [15:0] MASK_TRIM = 16'h00ff;
    localparam logic [15:0] MASK_HOLD = 16'hffff;
    localparam logic [15:0] MASK_BAND = 16'hffff;
    localparam logic [15:0] MASK_DAMP = 16'h3f3f;

    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 8;
    localparam int TRIM_FRAC_BITS = 20;
    localparam int TRIM_SPAN_BITS = 13;

    localparam int HOLD_COARSE_LSB = 11;
    localparam int HOLD_FINE_LSB = 8;
    localparam int HOLD_HIST_LSB = 4;
    localparam int LOL_LIMIT_LSB = 0;
    localparam logic [4:0] HOLD_COARSE_MAX = 5'h14;
    localparam logic [3:0] HIST_MAX_CODE = 4'ha;

    localparam int ACQ_BAND_COARSE_LSB = 11;
    localparam int ACQ_BAND_FINE_LSB = 8;
    localparam int LOCKED_BAND_COARSE_LSB = 3;
    localparam int LOCKED_BAND_FINE_LSB = 0;
    localparam int ACQ_DAMP_COARSE_LSB = 11;
    localparam int ACQ_DAMP_FINE_LSB = 8;
    localparam int LOCKED_DAMP_COARSE_LSB = 3;
    localparam int LOCKED_DAMP_FINE_LSB = 0;

    typedef struct packed {
        logic [4:0] band_coarse;
        logic [2:0] band_fine;
        logic [2:0] damp_coarse;
        logic [2:0] damp_fine;
        logic use_acquire;
    } loop_set_s;

    typedef struct packed {
        logic [4:0] coarse;
        logic [2:0] fine;
        logic bypass;
        logic [3:0] history_sec;
        logic instant;
    } hold_set_s;

endpackage

// File: core/loop_set_select.sv
// Picks the Acquire or Normal loop filter bandwidth and damping set
`timescale 1ns/1ps
module loop_set_select (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] band_reg,
    input wire logic [15:0] damp_reg,
    input wire logic in_acquire,
    input wire logic auto_filter_set_switch,
    input wire logic hold_update,
    output loop_cfg_pkg::loop_set_s loop_set
);

    loop_cfg_pkg::loop_set_s next_loop_set;
    logic acq;

    always_comb begin
        acq = in_acquire && auto_filter_set_switch;
        next_loop_set = loop_set;
        // Freeze while the host rewrites, so the filter never sees a half-written set
        if (!hold_update) begin
            next_loop_set.use_acquire = acq;
            if (acq) begin
                next_loop_set.band_coarse = band_reg[loop_cfg_pkg::ACQ_BAND_COARSE_LSB +: 5];
                next_loop_set.band_fine = band_reg[loop_cfg_pkg::ACQ_BAND_FINE_LSB +: 3];
                next_loop_set.damp_coarse = damp_reg[loop_cfg_pkg::ACQ_DAMP_COARSE_LSB +: 3];
                next_loop_set.damp_fine = damp_reg[loop_cfg_pkg::ACQ_DAMP_FINE_LSB +: 3];
            end else begin
                next_loop_set.band_coarse = band_reg[loop_cfg_pkg::LOCKED_BAND_COARSE_LSB +: 5];
                next_loop_set.band_fine = band_reg[loop_cfg_pkg::LOCKED_BAND_FINE_LSB +: 3];
                next_loop_set.damp_coarse = damp_reg[loop_cfg_pkg::LOCKED_DAMP_COARSE_LSB +: 3];
                next_loop_set.damp_fine = damp_reg[loop_cfg_pkg::LOCKED_DAMP_FINE_LSB +: 3];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            // Normal-state reset fields: coarse 0xB, fine 0, damping 0 and 1
            loop_set <= '{band_coarse: 5'h0b, band_fine: 3'h0, damp_coarse: 3'h0,
                          damp_fine: 3'h1, use_acquire: 1'b0};
        end else begin
            loop_set <= next_loop_set;
        end
    end

endmodule // loop_set_select

// File: core/dpll_loop_filter_config_regs.sv
// Loop filter, holdover and crystal trim configuration register bank
`timescale 1ns/1ps
module dpll_loop_filter_config_regs #(
    parameter int LOL_W = 8,
    parameter int CORR_FRAC = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [LOL_W-1:0] lol_count,
    input wire logic in_acquire,
    input wire logic auto_filter_set_switch,
    input wire logic filter_update_dis,
    output logic signed [7:0] crystal_trim,
    output logic signed [CORR_FRAC:0] crystal_correction,
    output loop_cfg_pkg::hold_set_s hold_set,
    output logic lock_loss_flag,
    output loop_cfg_pkg::loop_set_s loop_set
);

    logic [15:0] crystal_offset_trim;
    logic [15:0] holdover_setup;
    logic [15:0] loop_filter_bandwidth;
    logic [15:0] loop_filter_damping;
    logic [15:0] next_crystal_offset_trim;
    logic [15:0] next_holdover_setup;
    logic [15:0] next_loop_filter_bandwidth;
    logic [15:0] next_loop_filter_damping;

    logic [15:0] next_reg_rdata;
    logic next_reg_rvalid;

    logic signed [7:0] next_crystal_trim;
    logic signed [CORR_FRAC:0] next_crystal_correction;
    loop_cfg_pkg::hold_set_s next_hold_set;
    logic next_lock_loss_flag;

    logic [4:0] hold_filter_coarse;
    logic [2:0] hold_filter_fine;
    logic [3:0] hold_history;
    logic [3:0] lock_loss_limit;

    // Holdover output reset values follow the holdover reset word
    localparam logic [4:0] HOLD_COARSE_RST =
        loop_cfg_pkg::RST_HOLD[loop_cfg_pkg::HOLD_COARSE_LSB +: 5];
    localparam logic [2:0] HOLD_FINE_RST =
        loop_cfg_pkg::RST_HOLD[loop_cfg_pkg::HOLD_FINE_LSB +: 3];
    localparam logic [3:0] HOLD_HIST_RST =
        loop_cfg_pkg::RST_HOLD[loop_cfg_pkg::HOLD_HIST_LSB +: 4];

    // Register writes; only implemented bits are ever stored
    always_comb begin
        next_crystal_offset_trim = crystal_offset_trim;
        next_holdover_setup = holdover_setup;
        next_loop_filter_bandwidth = loop_filter_bandwidth;
        next_loop_filter_damping = loop_filter_damping;
        if (reg_wr) begin
            case (reg_addr)
                loop_cfg_pkg::IDX_TRIM: begin
                    next_crystal_offset_trim = reg_wdata & loop_cfg_pkg::MASK_TRIM;
                end
                loop_cfg_pkg::IDX_HOLD: begin
                    next_holdover_setup = reg_wdata & loop_cfg_pkg::MASK_HOLD;
                end
                loop_cfg_pkg::IDX_BAND: begin
                    next_loop_filter_bandwidth = reg_wdata & loop_cfg_pkg::MASK_BAND;
                end
                loop_cfg_pkg::IDX_DAMP: begin
                    next_loop_filter_damping = reg_wdata & loop_cfg_pkg::MASK_DAMP;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            crystal_offset_trim <= loop_cfg_pkg::RST_TRIM;
            holdover_setup <= loop_cfg_pkg::RST_HOLD;
            loop_filter_bandwidth <= loop_cfg_pkg::RST_BAND;
            loop_filter_damping <= loop_cfg_pkg::RST_DAMP;
        end else begin
            crystal_offset_trim <= next_crystal_offset_trim;
            holdover_setup <= next_holdover_setup;
            loop_filter_bandwidth <= next_loop_filter_bandwidth;
            loop_filter_damping <= next_loop_filter_damping;
        end
    end

    // Read port: data one cycle after the strobe; a same-cycle write is not seen yet
    always_comb begin
        next_reg_rvalid = reg_rd;
        next_reg_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                loop_cfg_pkg::IDX_TRIM: next_reg_rdata = crystal_offset_trim;
                loop_cfg_pkg::IDX_HOLD: next_reg_rdata = holdover_setup;
                loop_cfg_pkg::IDX_BAND: next_reg_rdata = loop_filter_bandwidth;
                loop_cfg_pkg::IDX_DAMP: begin
                    next_reg_rdata = loop_filter_damping & loop_cfg_pkg::MASK_DAMP;
                end
                default: next_reg_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    // Field extraction
    always_comb begin
        hold_filter_coarse = holdover_setup[loop_cfg_pkg::HOLD_COARSE_LSB +: 5];
        hold_filter_fine = holdover_setup[loop_cfg_pkg::HOLD_FINE_LSB +: 3];
        hold_history = holdover_setup[loop_cfg_pkg::HOLD_HIST_LSB +: 4];
        lock_loss_limit = holdover_setup[loop_cfg_pkg::LOL_LIMIT_LSB +: 4];
    end

    // Trim as a fixed-point correction with CORR_FRAC fraction bits;
    // CORR_FRAC below 20 would lose resolution, so keep it at or above that
    always_comb begin
        next_crystal_trim = signed'(crystal_offset_trim[loop_cfg_pkg::TRIM_LSB +: 8]);
        next_crystal_correction = (CORR_FRAC + 1)'(next_crystal_trim)
            <<< (CORR_FRAC - loop_cfg_pkg::TRIM_FRAC_BITS);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            crystal_trim <= 8'sh00;
            crystal_correction <= '0;
        end else begin
            crystal_trim <= next_crystal_trim;
            crystal_correction <= next_crystal_correction;
        end
    end

    // Holdover filter controls
    always_comb begin
        next_hold_set = hold_set;
        if (hold_filter_coarse > loop_cfg_pkg::HOLD_COARSE_MAX) begin
            next_hold_set.coarse = loop_cfg_pkg::HOLD_COARSE_MAX;
        end else begin
            next_hold_set.coarse = hold_filter_coarse;
        end
        next_hold_set.fine = hold_filter_fine;
        // Either field at zero means unlimited bandwidth
        next_hold_set.bypass = (hold_filter_coarse == 5'h00) || (hold_filter_fine == 3'h0);
        next_hold_set.instant = (hold_history == 4'h0);
        if (hold_history > loop_cfg_pkg::HIST_MAX_CODE) begin
            // Undefined codes saturate at the longest history
            next_hold_set.history_sec = loop_cfg_pkg::HIST_MAX_CODE;
        end else begin
            next_hold_set.history_sec = hold_history;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_set <= '{coarse: HOLD_COARSE_RST, fine: HOLD_FINE_RST,
                          bypass: (HOLD_COARSE_RST == 5'h00) || (HOLD_FINE_RST == 3'h0),
                          history_sec: HOLD_HIST_RST, instant: HOLD_HIST_RST == 4'h0};
        end else begin
            hold_set <= next_hold_set;
        end
    end

    // Loss-of-lock limit, compared at counter width
    always_comb begin
        next_lock_loss_flag = lol_count > LOL_W'(lock_loss_limit);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_loss_flag <= 1'b0;
        end else begin
            lock_loss_flag <= next_lock_loss_flag;
        end
    end

    loop_set_select u_loop_set_select (
        .mclk(mclk),
        .rst(rst),
        .band_reg(loop_filter_bandwidth),
        .damp_reg(loop_filter_damping),
        .in_acquire(in_acquire),
        .auto_filter_set_switch(auto_filter_set_switch),
        .hold_update(filter_update_dis),
        .loop_set(loop_set)
    );

endmodule // dpll_loop_filter_config_regs

// File: verif/dpll_loop_filter_config_regs_sva.sv
// Port-level checks for the loop filter configuration bank
`timescale 1ns/1ps
module dpll_loop_filter_config_regs_sva #(
    parameter int LOL_W = 8,
    parameter int CORR_FRAC = 24
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [LOL_W-1:0] lol_count,
    input wire logic in_acquire,
    input wire logic auto_filter_set_switch,
    input wire logic filter_update_dis,
    input wire logic signed [7:0] crystal_trim,
    input wire logic signed [CORR_FRAC:0] crystal_correction,
    input wire loop_cfg_pkg::hold_set_s hold_set,
    input wire logic lock_loss_flag,
    input wire loop_cfg_pkg::loop_set_s loop_set
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_trim_rd; reg_rd && reg_addr == 2'h0 |=> reg_rvalid && reg_rdata[15:8] == 8'h00;
    endproperty
    a_trim_rd: assert property (p_trim_rd) else $error("trim upper byte read nonzero");
    property p_corr; crystal_correction == crystal_trim * (1 << (CORR_FRAC - 20)); endproperty
    a_corr: assert property (p_corr) else $error("correction not scaled trim");
    property p_bypass; hold_set.bypass == (hold_set.coarse == 5'h00 || hold_set.fine == 3'h0);
    endproperty
    a_bypass: assert property (p_bypass) else $error("holdover bypass wrong");
    property p_clamp; hold_set.coarse <= 5'h14; endproperty
    a_clamp: assert property (p_clamp) else $error("holdover coarse above limit");
    property p_hist; hold_set.history_sec <= 4'ha && hold_set.instant == (hold_set.history_sec == 4'h0);
    endproperty
    a_hist: assert property (p_hist) else $error("history output wrong");
    property p_lol_low; lol_count == '0 |=> !lock_loss_flag; endproperty
    a_lol_low: assert property (p_lol_low) else $error("flag with zero count");
    property p_lol_high; lol_count > 15 |=> lock_loss_flag; endproperty
    a_lol_high: assert property (p_lol_high) else $error("flag missing above any limit");
    property p_use_acq; !filter_update_dis |=>
        loop_set.use_acquire == $past(in_acquire && auto_filter_set_switch); endproperty
    a_use_acq: assert property (p_use_acq) else $error("acquire set selection wrong");
    property p_freeze; filter_update_dis |=> $stable(loop_set); endproperty
    a_freeze: assert property (p_freeze) else $error("loop set moved while frozen");
    property p_damp_rd; reg_rd && reg_addr == 2'h3 |=>
        reg_rvalid && reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0; endproperty
    a_damp_rd: assert property (p_damp_rd) else $error("damping reserved bits nonzero");
endmodule // dpll_loop_filter_config_regs_sva

bind dpll_loop_filter_config_regs dpll_loop_filter_config_regs_sva #(.LOL_W(LOL_W),
    .CORR_FRAC(CORR_FRAC)) u_sva (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lol_count(lol_count), .in_acquire(in_acquire), .auto_filter_set_switch(auto_filter_set_switch),
    .filter_update_dis(filter_update_dis), .crystal_trim(crystal_trim),
    .crystal_correction(crystal_correction), .hold_set(hold_set),
    .lock_loss_flag(lock_loss_flag), .loop_set(loop_set));

// File: verif/test_dpll_loop_filter_config_regs.sv
// Self-checking bench for the loop filter configuration bank
`timescale 1ns/1ps
module test_dpll_loop_filter_config_regs;
    localparam int CF = 24;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, lock_loss_flag, reg_rvalid;
    logic in_acquire = 0, auto_filter_set_switch = 0, filter_update_dis = 0;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [7:0] lol_count = 8'h00;
    logic signed [7:0] crystal_trim;
    logic signed [CF:0] crystal_correction;
    loop_cfg_pkg::hold_set_s hold_set;
    loop_cfg_pkg::loop_set_s loop_set;
    int n_fail = 0, check_count = 0;
    always #25 mclk = ~mclk;
    dpll_loop_filter_config_regs #(.LOL_W(8), .CORR_FRAC(CF)) dut (.mclk(mclk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lol_count(lol_count),
        .in_acquire(in_acquire), .auto_filter_set_switch(auto_filter_set_switch),
        .filter_update_dis(filter_update_dis), .crystal_trim(crystal_trim),
        .crystal_correction(crystal_correction), .hold_set(hold_set),
        .lock_loss_flag(lock_loss_flag), .loop_set(loop_set));
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Outputs settle one registered stage after the write edge
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        @(negedge mclk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 0;
        chk({reg_rvalid, reg_rdata}, {1'b1, e}, "read");
    endtask
    task automatic step(); @(negedge mclk); endtask
    task automatic t_reset();
        rd(2'h0, 16'h0000);
        rd(2'h1, 16'h3800);
        rd(2'h2, 16'h7058);
        rd(2'h3, 16'h2901);
        chk(hold_set, {5'h07, 3'h0, 1'b1, 4'h0, 1'b1}, "hold reset");
        chk(loop_set, {5'h0b, 3'h0, 3'h0, 3'h1, 1'b0}, "normal reset");
        in_acquire = 1;
        auto_filter_set_switch = 1;
        step();
        chk(loop_set, {5'h0e, 3'h0, 3'h5, 3'h1, 1'b1}, "acquire reset");
    endtask
    task automatic t_trim();
        logic [7:0] v[2];
        logic signed [CF:0] ec;
        v = '{8'h80, 8'h7f};
        for (int i = 0; i < 2; i++) begin
            wr(2'h0, {8'hff, v[i]});
            rd(2'h0, {8'h00, v[i]});
            ec = (CF + 1)'($signed(v[i]) * (1 << (CF - 20)));
            chk({crystal_trim}, {24'h0, v[i]}, "trim");
            chk({crystal_correction}, {ec}, "correction");
        end
    endtask
    task automatic t_hold();
        wr(2'h1, 16'hfbc5);
        rd(2'h1, 16'hfbc5);
        chk(hold_set, {5'h14, 3'h3, 1'b0, 4'ha, 1'b0}, "hold clamp");
        lol_count = 8'h05;
        step();
        chk(lock_loss_flag, 1'b0, "flag at limit");
        lol_count = 8'h06;
        step();
        chk(lock_loss_flag, 1'b1, "flag above limit");
        wr(2'h1, 16'h0205);
        chk(hold_set, {5'h00, 3'h2, 1'b1, 4'h0, 1'b1}, "hold bypass");
        wr(2'h1, 16'h003f);
        chk(hold_set, {5'h00, 3'h0, 1'b1, 4'h3, 1'b0}, "hold history");
        lol_count = 8'h0f;
        step();
        chk(lock_loss_flag, 1'b0, "flag at top limit");
        lol_count = 8'h10;
        step();
        chk(lock_loss_flag, 1'b1, "flag above top limit");
        lol_count = 8'h00;
    endtask
    task automatic t_loop();
        wr(2'h2, 16'h9a63);
        wr(2'h3, 16'hd1e2);
        rd(2'h3, 16'h1122);
        chk(loop_set, {5'h13, 3'h2, 3'h2, 3'h1, 1'b1}, "acquire set");
        auto_filter_set_switch = 0;
        step();
        chk(loop_set, {5'h0c, 3'h3, 3'h4, 3'h2, 1'b0}, "switch off");
        filter_update_dis = 1;
        auto_filter_set_switch = 1;
        wr(2'h2, 16'h0000);
        chk(loop_set, {5'h0c, 3'h3, 3'h4, 3'h2, 1'b0}, "frozen");
        filter_update_dis = 0;
        in_acquire = 0;
        step();
        chk(loop_set, {5'h00, 3'h0, 3'h4, 3'h2, 1'b0}, "released");
    endtask
    // Mid-run reset must restore the trim, holdover and damping words and the trim, holdover and loop set outputs
    task automatic t_rerst();
        rst = 1;
        repeat (2) step();
        rst = 0;
        rd(2'h0, 16'h0000);
        rd(2'h1, 16'h3800);
        rd(2'h3, 16'h2901);
        chk({crystal_trim}, 8'h00, "trim after reset");
        chk(hold_set, {5'h07, 3'h0, 1'b1, 4'h0, 1'b1}, "hold after reset");
        chk(loop_set, {5'h0b, 3'h0, 3'h0, 3'h1, 1'b0}, "normal after reset");
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        rst = 0;
        t_reset();
        t_trim();
        t_hold();
        t_loop();
        t_rerst();
        finish_test();
    end
    // Whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        n_fail++;
        finish_test();
    end
endmodule // test_dpll_loop_filter_config_regs
